// file: logic/srm_row_mux.sv
// Row address multiplexer of the synchronous DRAM controller
module srm_row_mux
    import srm_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   cfg_we,
    input  wire logic [7:0]             cfg_wdata,
    input  wire logic                   sdram_mode,
    input  wire logic [1:0]             bus_width,
    input  wire logic                   row_phase,
    input  wire logic [SRM_IADDR_W-1:0] int_addr,
    output logic      [SRM_SEL_W-1:0]   row_shift_select,
    output logic                        sel_invalid,
    output logic      [SRM_XADDR_W-1:0] ext_addr
);

    // ==========================================================
    // Selector register
    logic [SRM_SEL_W-1:0] sel_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= SRM_SEL_RESET; // RULE1
        end else if (cfg_we) begin
            sel_q <= cfg_wdata[SRM_SEL_MSB:SRM_SEL_LSB]; // RULE1
        end
    end

    assign row_shift_select = sel_q;

    // ==========================================================
    // Start bit decode
    logic [4:0] sync_start;
    logic       sync_ok;
    logic [4:0] start_bit;

    // Each legal code names the internal bit that lands on line A1
    always_comb begin
        sync_ok    = 1'b1;
        sync_start = SRM_START_A9;
        case (sel_q)
            SRM_SEL_1MX16: begin
                sync_start = SRM_START_A9; // RULE3
            end
            SRM_SEL_2MX16: begin
                sync_start = SRM_START_A10; // RULE4
            end
            SRM_SEL_512KX32: begin
                sync_start = SRM_START_A9; // RULE5
            end
            SRM_SEL_4MX16: begin
                sync_start = SRM_START_A10; // RULE6
            end
            SRM_SEL_8MX16: begin
                sync_start = SRM_START_A11; // RULE7
            end
            default: begin
                // Illegal codes keep the A9 start so the pins stay defined
                sync_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Interface dependent shift
    logic [4:0] plain_start;

    // Plain DRAM places the row one bit lower for the same code
    assign plain_start = sync_start - SRM_DRAM_ADJ; // RULE2
    assign start_bit   = sdram_mode ? sync_start : plain_start; // RULE2

    // ==========================================================
    // Misuse causes
    // Each cause is kept apart so a waveform shows which limit was broken
    logic code_reserved;
    logic code_noset;
    logic wide_conflict;
    logic narrow_conflict;

    always_comb begin
        code_reserved = 1'b0;
        code_noset    = 1'b0;
        if (!sync_ok) begin
            if (sel_q == SRM_SEL_NOSET) begin
                code_noset = 1'b1; // RULE11
            end else begin
                code_reserved = 1'b1; // RULE10
            end
        end
    end

    always_comb begin
        wide_conflict   = 1'b0;
        narrow_conflict = 1'b0;
        if (sel_q == SRM_SEL_8MX16 && bus_width == SRM_BUS_32) begin
            wide_conflict = 1'b1; // RULE8
        end
        if (sel_q == SRM_SEL_512KX32 && bus_width == SRM_BUS_16) begin
            narrow_conflict = 1'b1; // RULE9
        end
    end

    // ==========================================================
    // Misuse flag; software is expected never to cause it
    logic bad_d;
    logic bad_q;

    // The codes only bind the synchronous interface, so plain DRAM never
    // raises the flag; the flag is a warning, the pins are not blocked
    always_comb begin
        bad_d = 1'b0;
        if (sdram_mode) begin
            bad_d = code_reserved | code_noset | wide_conflict | narrow_conflict;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bad_q <= 1'b0;
        end else begin
            bad_q <= bad_d;
        end
    end

    assign sel_invalid = bad_q;

    // ==========================================================
    // Row slice selection
    logic [SRM_XADDR_W-1:0] row_addr;

    srm_shifter u_shift (
        .int_addr  (int_addr),
        .start_bit (start_bit),
        .row_addr  (row_addr)
    );

    // ==========================================================
    // Address pins
    logic [SRM_XADDR_W-1:0] ext_addr_q;

    // Registered so the pins change only on clock edges; outside the row
    // phase the low address bits pass straight through
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_addr_q <= '0;
        end else if (row_phase) begin
            ext_addr_q <= row_addr; // RULE12
        end else begin
            ext_addr_q <= int_addr[SRM_XADDR_W-1:0];
        end
    end

    assign ext_addr = ext_addr_q;

endmodule

// file: logic/srm_pkg.sv
// Constants shared by the synchronous DRAM row address multiplexer
// Summary of operation
// [RULE1] Four-bit selector, bits 6..3, resets to zero
// [RULE2] Shift differs between plain and synchronous DRAM
// [RULE3] Code 0100: row starts at A9 on A1
// [RULE4] Code 0101: row starts at A10 on A1
// [RULE5] Code 0111: row starts at A9 on A1
// [RULE6] Code 1101: row starts at A10 on A1
// [RULE7] Code 1110: row starts at A11 on A1
// [RULE8] Software avoids 1110 on 32-bit bus
// [RULE9] Software avoids 0111 on 16-bit bus
// [RULE10] Software never writes reserved codes for synchronous DRAM
// [RULE11] Software never programs code 0110
// [RULE12] Higher lines follow higher bits without gaps
package srm_pkg;

    // ==========================================================
    // Field layout
    localparam int unsigned SRM_SEL_MSB   = 6;
    localparam int unsigned SRM_SEL_LSB   = 3;
    localparam int unsigned SRM_SEL_W     = 4;
    localparam logic [3:0]  SRM_SEL_RESET = 4'h0;

    // ==========================================================
    // Address widths
    localparam int unsigned SRM_IADDR_W   = 26;
    localparam int unsigned SRM_XADDR_W   = 15;
    localparam int unsigned SRM_ROW_W     = 13;
    localparam logic [4:0]  SRM_ROW_BASE  = 5'h01;

    // ==========================================================
    // Selector codes
    localparam logic [3:0] SRM_SEL_1MX16  = 4'h4;
    localparam logic [3:0] SRM_SEL_2MX16  = 4'h5;
    localparam logic [3:0] SRM_SEL_NOSET  = 4'h6;
    localparam logic [3:0] SRM_SEL_512KX32 = 4'h7;
    localparam logic [3:0] SRM_SEL_4MX16  = 4'hd;
    localparam logic [3:0] SRM_SEL_8MX16  = 4'he;

    // Internal bit that lands on external A1 for each start point
    localparam logic [4:0] SRM_START_A9   = 5'h09;
    localparam logic [4:0] SRM_START_A10  = 5'h0a;
    localparam logic [4:0] SRM_START_A11  = 5'h0b;

    // Plain DRAM shift: one bit less than synchronous for the same code
    localparam logic [4:0] SRM_DRAM_ADJ   = 5'h01;

    typedef enum logic [1:0] {
        SRM_BUS_8  = 2'b00,
        SRM_BUS_16 = 2'b01,
        SRM_BUS_32 = 2'b10
    } srm_bus_t;

endpackage

// file: logic/srm_shifter.sv
// Barrel selector that places the row address slice onto the external lines
module srm_shifter
    import srm_pkg::*;
(
    input  wire logic [SRM_IADDR_W-1:0] int_addr,
    input  wire logic [4:0]             start_bit,
    output logic      [SRM_XADDR_W-1:0] row_addr
);

    // ==========================================================
    // Per-line selection
    genvar g;
    generate
        for (g = 0; g < SRM_XADDR_W; g++) begin : g_line
            if (g < int'(SRM_ROW_BASE) || g >= int'(SRM_ROW_BASE) + int'(SRM_ROW_W)) begin : g_idle
                // Lines outside the row slice carry nothing during the row phase
                assign row_addr[g] = 1'b0;
            end else begin : g_row
                logic [5:0] src;
                assign src = 6'(start_bit) + 6'(g) - 6'(SRM_ROW_BASE);
                // Consecutive lines take consecutive bits, no gaps
                assign row_addr[g] = (src < 6'(SRM_IADDR_W)) ? int_addr[src[4:0]] : 1'b0; // RULE12
            end
        end
    endgenerate

endmodule

// file: tb/srm_row_mux_assertions.sv
// Checker of the row address multiplexer
module srm_row_mux_assertions
    import srm_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   rst_b,
    input wire logic                   cfg_we,
    input wire logic [7:0]             cfg_wdata,
    input wire logic                   sdram_mode,
    input wire logic [1:0]             bus_width,
    input wire logic                   row_phase,
    input wire logic [SRM_IADDR_W-1:0] int_addr,
    input wire logic [SRM_SEL_W-1:0]   row_shift_select,
    input wire logic                   sel_invalid,
    input wire logic [SRM_XADDR_W-1:0] ext_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic       rp  = row_phase && sdram_mode;
    wire logic [3:0] sel = row_shift_select;
    property p_ld; cfg_we |=> sel == $past(cfg_wdata[6:3]); endproperty
    property p_c4; rp && sel == 4'h4 |=> ext_addr[1] == $past(int_addr[9]); endproperty
    property p_c5; rp && sel == 4'h5 |=> ext_addr[1] == $past(int_addr[10]); endproperty
    property p_c7; rp && sel == 4'h7 |=> ext_addr[1] == $past(int_addr[9]); endproperty
    property p_cd; rp && sel == 4'hd |=> ext_addr[1] == $past(int_addr[10]); endproperty
    property p_ce; rp && sel == 4'he |=> ext_addr[1] == $past(int_addr[11]); endproperty
    property p_pl; row_phase && !sdram_mode && sel == 4'h5 |=> ext_addr[1] == $past(int_addr[9]);
    endproperty
    property p_rw; rp && sel == 4'he |=> ext_addr[13:1] == $past(int_addr[23:11]); endproperty
    property p_iv; sdram_mode && sel == 4'h0 |=> sel_invalid; endproperty
    property p_wd; sdram_mode && sel == 4'he && bus_width == 2'h1 |=> !sel_invalid; endproperty
    a_ld: assert property (p_ld) else $error("selector load");
    a_c4: assert property (p_c4) else $error("start 9");
    a_c5: assert property (p_c5) else $error("start 10");
    a_c7: assert property (p_c7) else $error("start 9");
    a_cd: assert property (p_cd) else $error("start 10");
    a_ce: assert property (p_ce) else $error("start 11");
    a_pl: assert property (p_pl) else $error("plain start");
    a_rw: assert property (p_rw) else $error("row slice");
    a_iv: assert property (p_iv) else $error("reserved code not flagged");
    a_wd: assert property (p_wd) else $error("legal width flagged");
endmodule
bind srm_row_mux srm_row_mux_assertions i_chk (
    .clock            (clock),
    .rst_b            (rst_b),
    .cfg_we           (cfg_we),
    .cfg_wdata        (cfg_wdata),
    .sdram_mode       (sdram_mode),
    .bus_width        (bus_width),
    .row_phase        (row_phase),
    .int_addr         (int_addr),
    .row_shift_select (row_shift_select),
    .sel_invalid      (sel_invalid),
    .ext_addr         (ext_addr)
);

// file: tb/srm_sdram_model.sv
// Memory model that latches the row address on bank activation
module srm_sdram_model (
    input wire logic        clock,
    input wire logic        act,
    input wire logic [14:0] ext_addr,
    output logic     [12:0] row_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic act_q;
    always_ff @(posedge clock) begin
        act_q <= act;
        if (act_q) row_q <= ext_addr[13:1];
    end
endmodule

// file: tb/srm_row_mux_test.sv
// Self-checking bench of the row address multiplexer
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %0t %h %h", $time, g, e); end end
module srm_row_mux_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rst_b = 0, cfg_we = 0, sdram_mode = 1, row_phase = 0;
    logic [7:0]  cfg_wdata = 8'h00;
    logic [1:0]  bus_width = 2'h1;
    logic [25:0] int_addr = 26'h0;
    logic [3:0]  row_shift_select;
    logic [14:0] ext_addr;
    logic [12:0] row_q;
    logic        sel_invalid;
    int          failures = 0, checks = 0;
    srm_row_mux i_dut (.clock, .rst_b, .cfg_we, .cfg_wdata, .sdram_mode, .bus_width,
        .row_phase, .int_addr, .row_shift_select, .sel_invalid, .ext_addr);
    srm_sdram_model i_mem (.clock, .act(row_phase), .ext_addr, .row_q);
    initial forever #25 clock = ~clock;
    // Unused byte bits are set so a wrong field position shows up
    task automatic row_chk(input logic [3:0] c, input logic [1:0] w, input logic sd,
                           input int st);
        logic [25:0] a;
        a = 26'h2b5a5c3 ^ {c, 22'h0};
        @(negedge clock);
        cfg_we = 1;
        cfg_wdata = {1'b1, c, 3'h7};
        bus_width = w;
        sdram_mode = sd;
        @(negedge clock);
        cfg_we = 0;
        row_phase = 1;
        int_addr = a;
        @(negedge clock);
        row_phase = 0;
        `CHK(row_shift_select, c)
        `CHK(ext_addr, {1'b0, 13'(a >> st), 1'b0})
        `CHK(sel_invalid, 1'b0)
        @(negedge clock);
        `CHK(ext_addr, a[14:0])
        `CHK(row_q, 13'(a >> st))
    endtask
    // Reset leaves code 0 in place, which the synchronous interface flags
    task automatic t_reset(input int n);
        rst_b = 0;
        sdram_mode = 1;
        repeat (n) @(negedge clock);
        `CHK(row_shift_select, 4'h0)
        `CHK(ext_addr, 15'h0)
        `CHK(sel_invalid, 1'b0)
        rst_b = 1;
        @(negedge clock);
        `CHK(sel_invalid, 1'b1)
    endtask
    task automatic t_sync;
        row_chk(4'h4, 2'h1, 1, 9);
        row_chk(4'h5, 2'h2, 1, 10);
        row_chk(4'h7, 2'h2, 1, 9);
        row_chk(4'h7, 2'h0, 1, 9);
        row_chk(4'hd, 2'h1, 1, 10);
        row_chk(4'he, 2'h1, 1, 11);
    endtask
    task automatic t_plain;
        row_chk(4'h5, 2'h1, 0, 9);
        row_chk(4'hd, 2'h0, 0, 9);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        t_reset(8);
        t_sync();
        t_plain();
        t_reset(2);
        final_report();
    end
endmodule
